// ### core/psl_loader.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "psl_defines.svh"

// Notes on behaviour
// R1 - first write puts the device in programming state: 0x0001 to mode register 0x10
// R2 - last write starts measurements: 0x0002 to mode register
// R3 - registers not written keep device power-up defaults
// R4 - 0x0005 to 0x02 enables active-low interrupt drive
// R5 - 0x30a9 to 0x11 sets overrun drop, sample mode, 32-bit sums
// R6 - 0x000a to 0x12 gives 800 Hz sample rate
// R7 - all four photodiode segments feed channels 3 and 4
// R8 - 0x0116 to 0x14 activates both slots, infrared in A, red in B
// R9 - 0x0330 to 0x15 averages eight samples per slot
// R10 - 0x3005 at 0x23 red 100 mA, 0x3007 at 0x24 infrared 130 mA
// R11 - 0x0207 to 0x25 sets 593.75 ns fine setting both emitters
// R12 - 0x0319 to 0x30 and 0x35: 25 us offset, 3 us width
// R13 - 0x0813 to 0x31 and 0x36: 19 us period, eight pulses
// R14 - 0x21f3 to 0x39 and 0x3b: front-end fine offset, 15 us offset, 4 us window
// R15 - 0x1c36 to 0x42 and 0x44 selects gain, filter, reference, integrator
// R16 - 0x0040 to 0x4e runs converter clock only during conversion
// R17 - device then delivers 100 reads per second per slot
// R18 - output rate equals sample rate divided by averaged samples
// R19 - writes strictly in order, each finished before the next starts
module psl_loader
  import psl_pkg::*;
#(
  parameter int IDX_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software register port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata_q,
  // device write port
  output logic dev_wr_req_q,
  output logic [7:0] dev_wr_addr_q,
  output logic [15:0] dev_wr_data_q,
  input wire logic dev_wr_done,
  input wire logic dev_wr_error,
  // interrupt
  output logic irq_q
);

  initial begin
    if ((1 << IDX_W) < `PSL_SEQ_LEN) begin
      $error("psl_loader: index too narrow for sequence");
    end
  end

  // ----------------------------------------
  // sequence table
  // ----------------------------------------
  logic [IDX_W-1:0] idx_q;
  psl_write_t entry;

  // R1 first entry programming state
  // R2 last entry run command
  psl_seq_rom #(
    .IDX_W(IDX_W)
  ) u_rom (
    .index(idx_q),
    .entry(entry)
  );

  // ----------------------------------------
  // software decode
  // ----------------------------------------
  logic start_req;
  logic [1:0] irq_clear;
  logic mask_we;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  psl_phase_t phase_q;
  logic done_q;
  logic error_q;
  logic [1:0] irq_event;

  assign start_req = sw_wr && (sw_addr == `PSL_REG_CONTROL) && sw_wdata[`PSL_CTRL_START];
  assign irq_clear = (sw_wr && (sw_addr == `PSL_REG_IRQ_STATUS)) ? sw_wdata[1:0] : 2'h0;
  assign mask_we = sw_wr && (sw_addr == `PSL_REG_IRQ_MASK);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic last_entry;
  assign last_entry = (idx_q == IDX_W'(`PSL_SEQ_LEN - 1));

  // R19 ordered one at a time
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= PSL_PHASE_IDLE;
    end else begin
      unique case (phase_q)
        PSL_PHASE_IDLE: begin
          if (start_req) begin
            phase_q <= PSL_PHASE_ISSUE;
          end
        end
        PSL_PHASE_ISSUE: begin
          phase_q <= PSL_PHASE_WAIT;
        end
        PSL_PHASE_WAIT: begin
          if (dev_wr_error || (dev_wr_done && last_entry)) begin
            phase_q <= PSL_PHASE_IDLE;
          end else if (dev_wr_done) begin
            phase_q <= PSL_PHASE_ISSUE;
          end
        end
        // the unused fourth code falls back to idle
        default: begin
          phase_q <= PSL_PHASE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q <= '0;
    end else if (phase_q == PSL_PHASE_IDLE && start_req) begin
      idx_q <= '0;
    end else if (phase_q == PSL_PHASE_WAIT && dev_wr_done && !dev_wr_error && !last_entry) begin
      idx_q <= idx_q + IDX_W'(1);
    end
  end

  // R3 untouched registers left alone
  // request is a single-cycle pulse; address and data hold until the next issue
  always_ff @(posedge clk) begin
    if (reset) begin
      dev_wr_req_q <= 1'b0;
      dev_wr_addr_q <= 8'h00;
      dev_wr_data_q <= 16'h0000;
    end else begin
      dev_wr_req_q <= (phase_q == PSL_PHASE_ISSUE);
      if (phase_q == PSL_PHASE_ISSUE) begin
        dev_wr_addr_q <= entry.addr;
        dev_wr_data_q <= entry.data;
      end
    end
  end

  // R17 rate follows the loaded values
  // R18 sample rate over averaging
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
      error_q <= 1'b0;
    end else if (phase_q == PSL_PHASE_IDLE && start_req) begin
      done_q <= 1'b0;
      error_q <= 1'b0;
    end else if (phase_q == PSL_PHASE_WAIT && dev_wr_error) begin
      error_q <= 1'b1;
    end else if (phase_q == PSL_PHASE_WAIT && dev_wr_done && last_entry) begin
      done_q <= 1'b1;
    end
  end

  assign irq_event[`PSL_IRQ_DONE] = (phase_q == PSL_PHASE_WAIT) && dev_wr_done && !dev_wr_error && last_entry;
  assign irq_event[`PSL_IRQ_ERROR] = (phase_q == PSL_PHASE_WAIT) && dev_wr_error;

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  psl_irq #(
    .N(2)
  ) u_irq (
    .clk(clk),
    .reset(reset),
    .event_set(irq_event),
    .clear_ones(irq_clear),
    .mask_we(mask_we),
    .mask_wdata(sw_wdata[1:0]),
    .status_q(irq_status),
    .mask_q(irq_mask),
    .irq_q(irq_q)
  );

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_rdata_q <= 32'h0;
    end else if (sw_rd) begin
      unique case (sw_addr)
        `PSL_REG_CONTROL: sw_rdata_q <= {{(32-IDX_W){1'b0}}, idx_q};
        `PSL_REG_STATUS: sw_rdata_q <= {29'h0, error_q, done_q, phase_q != PSL_PHASE_IDLE};
        `PSL_REG_IRQ_STATUS: sw_rdata_q <= {30'h0, irq_status};
        `PSL_REG_IRQ_MASK: sw_rdata_q <= {30'h0, irq_mask};
        default: sw_rdata_q <= 32'h0;
      endcase
    end else begin
      sw_rdata_q <= 32'h0;
    end
  end

endmodule

// ### core/psl_defines.svh
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH

// device register offsets
`define PSL_DEV_INTERRUPT_PIN_CONTROL 8'h02
`define PSL_DEV_OPERATING_MODE 8'h10
`define PSL_DEV_SLOT_ENABLE_CONTROL 8'h11
`define PSL_DEV_SAMPLING_FREQUENCY 8'h12
`define PSL_DEV_DETECTOR_EMITTER_ROUTING 8'h14
`define PSL_DEV_SAMPLE_AVERAGING 8'h15
`define PSL_DEV_SLOT_A_CHAN1_DARK_OFFSET 8'h18
`define PSL_DEV_SLOT_A_CHAN2_DARK_OFFSET 8'h19
`define PSL_DEV_SLOT_A_CHAN3_DARK_OFFSET 8'h1a
`define PSL_DEV_SLOT_A_CHAN4_DARK_OFFSET 8'h1b
`define PSL_DEV_SLOT_B_CHAN1_DARK_OFFSET 8'h1e
`define PSL_DEV_SLOT_B_CHAN2_DARK_OFFSET 8'h1f
`define PSL_DEV_SLOT_B_CHAN3_DARK_OFFSET 8'h20
`define PSL_DEV_SLOT_B_CHAN4_DARK_OFFSET 8'h21
`define PSL_DEV_RED_EMITTER_COARSE_CURRENT 8'h23
`define PSL_DEV_IR_EMITTER_COARSE_CURRENT 8'h24
`define PSL_DEV_EMITTER_FINE_SETTING 8'h25
`define PSL_DEV_SLOT_A_EMITTER_TIMING 8'h30
`define PSL_DEV_SLOT_A_PULSE_TRAIN 8'h31
`define PSL_DEV_SLOT_B_EMITTER_TIMING 8'h35
`define PSL_DEV_SLOT_B_PULSE_TRAIN 8'h36
`define PSL_DEV_SLOT_A_FRONTEND_TIMING 8'h39
`define PSL_DEV_SLOT_B_FRONTEND_TIMING 8'h3b
`define PSL_DEV_SLOT_A_FRONTEND_GAIN 8'h42
`define PSL_DEV_SLOT_B_FRONTEND_GAIN 8'h44
`define PSL_DEV_CONVERTER_CLOCK_TIMING 8'h4e

// values written by the setup sequence
`define PSL_VAL_MODE_PROGRAM 16'h0001
`define PSL_VAL_MODE_RUN 16'h0002
`define PSL_VAL_INT_PIN 16'h0005
`define PSL_VAL_SLOT_EN 16'h30a9
`define PSL_VAL_FSAMPLE 16'h000a
`define PSL_VAL_ROUTING 16'h0116
`define PSL_VAL_AVERAGING 16'h0330
`define PSL_VAL_OFFSET_UNUSED 16'h3fff
`define PSL_VAL_OFFSET_HALF 16'h1ff0
`define PSL_VAL_RED_COARSE 16'h3005
`define PSL_VAL_IR_COARSE 16'h3007
`define PSL_VAL_FINE 16'h0207
`define PSL_VAL_EMITTER_TIMING 16'h0319
`define PSL_VAL_PULSE_TRAIN 16'h0813
`define PSL_VAL_FRONTEND_TIMING 16'h21f3
`define PSL_VAL_GAIN 16'h1c36
`define PSL_VAL_CONVERTER 16'h0040

// number of writes in the sequence
`define PSL_SEQ_LEN 27

// controller register offsets
`define PSL_REG_CONTROL 4'h0
`define PSL_REG_STATUS 4'h1
`define PSL_REG_IRQ_STATUS 4'h2
`define PSL_REG_IRQ_MASK 4'h3

// field positions
`define PSL_CTRL_START 0
`define PSL_STAT_BUSY 0
`define PSL_STAT_DONE 1
`define PSL_STAT_ERROR 2
`define PSL_IRQ_DONE 0
`define PSL_IRQ_ERROR 1

`endif

// ### core/psl_pkg.sv
package psl_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } psl_write_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } psl_cmd_t;

  typedef enum logic [1:0] {
    PSL_PHASE_IDLE,
    PSL_PHASE_ISSUE,
    PSL_PHASE_WAIT
  } psl_phase_t;

endpackage

// ### core/psl_seq_rom.sv
`timescale 1ns/1ps
`include "psl_defines.svh"

module psl_seq_rom
  import psl_pkg::*;
#(
  parameter int IDX_W = 5
) (
  // lookup
  input wire logic [IDX_W-1:0] index,
  output psl_write_t entry
);

  initial begin
    if ((1 << IDX_W) < `PSL_SEQ_LEN) begin
      $error("psl_seq_rom: index too narrow");
    end
  end

  always_comb begin
    entry = '{addr: `PSL_DEV_OPERATING_MODE, data: `PSL_VAL_MODE_PROGRAM};
    // R1 R2 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R15 R16 setup writes
    unique case (index)
      5'd0: entry = '{addr: `PSL_DEV_OPERATING_MODE, data: `PSL_VAL_MODE_PROGRAM};
      5'd1: entry = '{addr: `PSL_DEV_INTERRUPT_PIN_CONTROL, data: `PSL_VAL_INT_PIN};
      5'd2: entry = '{addr: `PSL_DEV_SLOT_ENABLE_CONTROL, data: `PSL_VAL_SLOT_EN};
      5'd3: entry = '{addr: `PSL_DEV_SAMPLING_FREQUENCY, data: `PSL_VAL_FSAMPLE};
      5'd4: entry = '{addr: `PSL_DEV_DETECTOR_EMITTER_ROUTING, data: `PSL_VAL_ROUTING};
      5'd5: entry = '{addr: `PSL_DEV_SAMPLE_AVERAGING, data: `PSL_VAL_AVERAGING};
      5'd6: entry = '{addr: `PSL_DEV_SLOT_A_CHAN1_DARK_OFFSET, data: `PSL_VAL_OFFSET_UNUSED};
      5'd7: entry = '{addr: `PSL_DEV_SLOT_A_CHAN2_DARK_OFFSET, data: `PSL_VAL_OFFSET_UNUSED};
      5'd8: entry = '{addr: `PSL_DEV_SLOT_A_CHAN3_DARK_OFFSET, data: `PSL_VAL_OFFSET_HALF};
      5'd9: entry = '{addr: `PSL_DEV_SLOT_A_CHAN4_DARK_OFFSET, data: `PSL_VAL_OFFSET_HALF};
      5'd10: entry = '{addr: `PSL_DEV_SLOT_B_CHAN1_DARK_OFFSET, data: `PSL_VAL_OFFSET_UNUSED};
      5'd11: entry = '{addr: `PSL_DEV_SLOT_B_CHAN2_DARK_OFFSET, data: `PSL_VAL_OFFSET_UNUSED};
      5'd12: entry = '{addr: `PSL_DEV_SLOT_B_CHAN3_DARK_OFFSET, data: `PSL_VAL_OFFSET_HALF};
      5'd13: entry = '{addr: `PSL_DEV_SLOT_B_CHAN4_DARK_OFFSET, data: `PSL_VAL_OFFSET_HALF};
      5'd14: entry = '{addr: `PSL_DEV_RED_EMITTER_COARSE_CURRENT, data: `PSL_VAL_RED_COARSE};
      5'd15: entry = '{addr: `PSL_DEV_IR_EMITTER_COARSE_CURRENT, data: `PSL_VAL_IR_COARSE};
      5'd16: entry = '{addr: `PSL_DEV_EMITTER_FINE_SETTING, data: `PSL_VAL_FINE};
      5'd17: entry = '{addr: `PSL_DEV_SLOT_A_EMITTER_TIMING, data: `PSL_VAL_EMITTER_TIMING};
      5'd18: entry = '{addr: `PSL_DEV_SLOT_A_PULSE_TRAIN, data: `PSL_VAL_PULSE_TRAIN};
      5'd19: entry = '{addr: `PSL_DEV_SLOT_B_EMITTER_TIMING, data: `PSL_VAL_EMITTER_TIMING};
      5'd20: entry = '{addr: `PSL_DEV_SLOT_B_PULSE_TRAIN, data: `PSL_VAL_PULSE_TRAIN};
      5'd21: entry = '{addr: `PSL_DEV_SLOT_A_FRONTEND_TIMING, data: `PSL_VAL_FRONTEND_TIMING};
      5'd22: entry = '{addr: `PSL_DEV_SLOT_B_FRONTEND_TIMING, data: `PSL_VAL_FRONTEND_TIMING};
      5'd23: entry = '{addr: `PSL_DEV_SLOT_A_FRONTEND_GAIN, data: `PSL_VAL_GAIN};
      5'd24: entry = '{addr: `PSL_DEV_SLOT_B_FRONTEND_GAIN, data: `PSL_VAL_GAIN};
      5'd25: entry = '{addr: `PSL_DEV_CONVERTER_CLOCK_TIMING, data: `PSL_VAL_CONVERTER};
      5'd26: entry = '{addr: `PSL_DEV_OPERATING_MODE, data: `PSL_VAL_MODE_RUN};
      default: entry = '{addr: `PSL_DEV_OPERATING_MODE, data: `PSL_VAL_MODE_PROGRAM};
    endcase
  end

endmodule

// ### core/psl_irq.sv
`timescale 1ns/1ps
`include "psl_defines.svh"

module psl_irq
  import psl_pkg::*;
#(
  parameter int N = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // events and software access
  input wire logic [N-1:0] event_set,
  input wire logic [N-1:0] clear_ones,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  // state
  output logic [N-1:0] status_q,
  output logic [N-1:0] mask_q,
  output logic irq_q
);

  initial begin
    if (N < 1) begin
      $error("psl_irq: need at least one event");
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_ones) | event_set;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= '0;
    end else if (mask_we) begin
      mask_q <= mask_wdata;
    end
  end

  // registered so the top output comes from a flip-flop
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~clear_ones) | event_set) & (mask_we ? mask_wdata : mask_q));
    end
  end

endmodule

// ### tb/psl_loader_monitor.sv
`timescale 1ns/1ps
module psl_loader_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata_q,
  // device port
  input wire logic dev_wr_req_q,
  input wire logic [7:0] dev_wr_addr_q,
  input wire logic [15:0] dev_wr_data_q,
  input wire logic dev_wr_done,
  input wire logic dev_wr_error,
  input wire logic irq_q
);
  logic pend_q;
  logic seen_q;
  logic last;
  assign last = dev_wr_addr_q == 8'h10 && dev_wr_data_q == 16'h0002;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----
  // write tracking
  // ----
  always_ff @(posedge clk) begin
    if (reset || (pend_q && (dev_wr_error || dev_wr_done))) begin
      pend_q <= 1'b0;
    end else if (dev_wr_req_q) begin
      pend_q <= 1'b1;
    end
  end
  // a run ends on an error or once the run command completes
  always_ff @(posedge clk) begin
    if (reset || (pend_q && (dev_wr_error || (dev_wr_done && last)))) begin
      seen_q <= 1'b0;
    end else if (dev_wr_req_q) begin
      seen_q <= 1'b1;
    end
  end
  req_one_cycle_a: assert property (dev_wr_req_q |=> !dev_wr_req_q)
    else $error("request wider than one cycle");
  req_not_pending_a: assert property (dev_wr_req_q |-> !pend_q)
    else $error("request while a write is pending");
  req_after_done_a: assert property (pend_q && dev_wr_done && !dev_wr_error && !last |-> ##2 dev_wr_req_q)
    else $error("next write not issued two cycles after done");
  addr_data_hold_a: assert property (!dev_wr_req_q |-> $stable(dev_wr_addr_q) && $stable(dev_wr_data_q))
    else $error("address or data moved between requests");
  abort_on_error_a: assert property (pend_q && dev_wr_error |=> !dev_wr_req_q [*8])
    else $error("write issued after an error");
  first_write_mode_a: assert property (dev_wr_req_q && !seen_q |-> dev_wr_addr_q == 8'h10 && dev_wr_data_q == 16'h0001)
    else $error("first write is not the programming command");
  mode_run_cmd_a: assert property (dev_wr_req_q && seen_q && dev_wr_addr_q == 8'h10 |-> dev_wr_data_q == 16'h0002)
    else $error("later mode write is not the run command");
  run_cmd_last_a: assert property (dev_wr_req_q && last |=> !dev_wr_req_q [*8])
    else $error("write issued after the run command");
endmodule

bind psl_loader psl_loader_monitor mon (
  .clk(clk),
  .reset(reset),
  .sw_addr(sw_addr),
  .sw_wdata(sw_wdata),
  .sw_wr(sw_wr),
  .sw_rd(sw_rd),
  .sw_rdata_q(sw_rdata_q),
  .dev_wr_req_q(dev_wr_req_q),
  .dev_wr_addr_q(dev_wr_addr_q),
  .dev_wr_data_q(dev_wr_data_q),
  .dev_wr_done(dev_wr_done),
  .dev_wr_error(dev_wr_error),
  .irq_q(irq_q)
);

// ### tb/psl_dev_model.sv
`timescale 1ns/1ps
module psl_dev_model (
  // host write port
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  input wire logic [7:0] addr,
  input wire logic [15:0] data,
  // answer delay and the write count that fails
  input wire logic [7:0] lat,
  input wire logic [7:0] fail_at,
  // answer
  output logic done,
  output logic error
);
  logic [15:0] regs [256];
  logic pend_q;
  logic [7:0] wait_q;
  logic [7:0] nwr_q;
  logic bad_write;
  logic running;
  assign running = regs[8'h10] == 16'h0002;
  // ----
  // register file
  // ----
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= 16'h0000;
      end
      regs[8'h01] <= 16'h00ff;
      regs[8'h11] <= 16'h1000;
      regs[8'h12] <= 16'h0028;
      regs[8'h14] <= 16'h0541;
      regs[8'h15] <= 16'h0600;
      bad_write <= 1'b0;
    end else if (req) begin
      bad_write <= bad_write | (addr != 8'h10 && regs[8'h10] != 16'h0001);
      regs[addr] <= data;
    end
  end
  // counts completed writes since reset; fail_at names one of them
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= 1'b0;
      wait_q <= 8'h00;
      nwr_q <= 8'h00;
      done <= 1'b0;
      error <= 1'b0;
    end else begin
      done <= 1'b0;
      error <= 1'b0;
      if (req) begin
        pend_q <= 1'b1;
        wait_q <= lat;
      end else if (pend_q && wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        nwr_q <= nwr_q + 8'h01;
        error <= nwr_q == fail_at;
        done <= nwr_q != fail_at;
      end
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench import psl_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata_q;
  logic dev_wr_req_q;
  logic [7:0] dev_wr_addr_q;
  logic [15:0] dev_wr_data_q;
  logic dev_wr_done;
  logic dev_wr_error;
  logic irq_q;
  logic [7:0] lat = 8'h00;
  logic [7:0] fail_at = 8'hff;
  logic [31:0] rv;
  int bad_count = 0;
  int checked = 0;
  int k = 0;
  psl_write_t exp_seq [27] = '{24'h100001, 24'h020005, 24'h1130a9, 24'h12000a, 24'h140116, 24'h150330,
    24'h183fff, 24'h193fff, 24'h1a1ff0, 24'h1b1ff0, 24'h1e3fff, 24'h1f3fff, 24'h201ff0, 24'h211ff0,
    24'h233005, 24'h243007, 24'h250207, 24'h300319, 24'h310813, 24'h350319, 24'h360813, 24'h3921f3,
    24'h3b21f3, 24'h421c36, 24'h441c36, 24'h4e0040, 24'h100002};
  always #10 clk = ~clk;
  psl_loader uut (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q), .dev_wr_req_q(dev_wr_req_q), .dev_wr_addr_q(dev_wr_addr_q),
    .dev_wr_data_q(dev_wr_data_q), .dev_wr_done(dev_wr_done), .dev_wr_error(dev_wr_error), .irq_q(irq_q));
  psl_dev_model dev (.clk(clk), .reset(reset), .req(dev_wr_req_q), .addr(dev_wr_addr_q),
    .data(dev_wr_data_q), .lat(lat), .fail_at(fail_at), .done(dev_wr_done), .error(dev_wr_error));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_wr <= w;
    sw_rd <= !w;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 rv = sw_rdata_q;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400; i++) begin
      acc(1'b0, 4'h1, 32'h0);
      if (rv[0] === 1'b0) break;
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // every device write is held against the setup order
  always @(posedge clk) begin
    if (dev_wr_req_q === 1'b1) begin
      chk({8'h0, dev_wr_addr_q, dev_wr_data_q}, {8'h0, exp_seq[k]});
      k = k + 1;
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd_chk(4'h3, 32'h0);
    acc(1'b1, 4'h3, 32'h3);
    rd_chk(4'h3, 32'h3);
    acc(1'b1, 4'h0, 32'h1);
    // a second start while busy must not restart the sequence
    acc(1'b1, 4'h0, 32'h1);
    rd_chk(4'h1, 32'h1);
    wait_idle();
    chk(k, 27);
    rd_chk(4'h1, 32'h2);
    rd_chk(4'h0, 32'h1a);
    rd_chk(4'h2, 32'h1);
    chk({31'h0, irq_q}, 32'h1);
    chk({16'h0, dev.regs[8'h01]}, 32'h00ff);
    chk({31'h0, dev.running}, 32'h1);
    chk({31'h0, dev.bad_write}, 32'h0);
    acc(1'b1, 4'h2, 32'h1);
    rd_chk(4'h2, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    // slow answers, the fourth write of the new run fails
    k = 0;
    lat <= 8'h03;
    fail_at <= 8'h1e;
    acc(1'b1, 4'h3, 32'h2);
    acc(1'b1, 4'h0, 32'h1);
    wait_idle();
    chk(k, 4);
    acc(1'b0, 4'h1, 32'h0);
    chk(rv & 32'h5, 32'h4);
    rd_chk(4'h0, 32'h3);
    rd_chk(4'h2, 32'h2);
    chk({31'h0, irq_q}, 32'h1);
    acc(1'b1, 4'h3, 32'h0);
    rd_chk(4'h7, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    stop_test();
  end
endmodule
